// file: src/cpu_state.sv
// CPU architectural state: register file, pointers, flag register, stack pointer
// Assumes the decoder drives one instruction's controls per cycle, synchronous to I_CLOCK
// Operation
// - Both operands come from any of 32 registers in the same cycle.
// - Interrupt entry and return never save or restore the flag register.
// - Flag register at data address 0x5F, I/O address 0x3F.
// - Flag register resets to zero; all eight bits read/write.
// - No interrupt is taken while global enable is clear; a request pending at a clear-enable instruction is still accepted next cycle.
// - Interrupt entry clears global enable; interrupt return sets it.
// - Set and clear enable instructions drive global enable.
// - Bit store copies register bit to copy bit; bit load copies back.
// - Sign flag equals negative xor overflow after each arithmetic unit update.
// - Bit 5 holds half carry, bit 3 overflow.
// - Bit 2 negative, bit 1 zero, bit 0 carry.
// - Flags update after every arithmetic unit operation with a nonzero mask.
// - File offers 8-bit and 16-bit read and write port mixes.
// - Registers occupy data addresses 0 to 31.
// - Registers 26 to 31 form three 16-bit pointers.
// - Pointers support displacement, post-increment and pre-decrement.
// - Push decrements stack pointer by one, pop increments by one.
// - Calls and interrupt entry subtract two, returns add two.
// - Stack pointer resets to 0x4FF; bits 15 to 11 read zero.
// - Stack pointer low at 0x5D, high at 0x5E.
// - Addresses from 0x60 reachable only by load and store.
// - Low byte write goes to temp; high write loads both together.
// - Low byte read latches high byte; high read returns it.
`timescale 1ns/1ns
`include "cpu_state_regs.svh"
module cpu_state
  import cpu_state_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Register file ports
  input wire logic [4:0] I_RD_A_SEL,
  input wire logic [4:0] I_RD_B_SEL,
  input wire logic I_RD_WIDE,
  input wire logic [4:0] I_WR_SEL,
  input wire logic I_WR_EN,
  input wire logic I_WR_WIDE,
  input wire logic [15:0] I_WR_DATA,
  // Arithmetic unit flag update
  input wire flag_upd_s I_FLAG_UPD,
  // Bit copy
  input wire logic I_BIT_STORE,
  input wire logic I_BIT_LOAD,
  input wire logic [2:0] I_BIT_SEL,
  // Interrupt control
  input wire logic I_IRQ_PENDING,
  input wire logic I_IRQ_TAKEN,
  input wire logic I_SET_IE,
  input wire logic I_CLR_IE,
  // Stack pointer
  input wire sp_op_e I_SP_OP,
  // Pointer access
  input wire logic [1:0] I_PTR_SEL,
  input wire ptr_mode_e I_PTR_MODE,
  input wire logic I_PTR_EN,
  input wire logic [5:0] I_PTR_DISP,
  // Data-space byte access
  input wire mem_acc_s I_MEM,
  // Register file read data
  output logic [7:0] O_RD_A,
  output logic [15:0] O_RD_B,
  // Pointer address and other status
  output logic [15:0] O_PTR_ADDR,
  output logic [7:0] O_FLAGS,
  output logic [15:0] O_SP,
  output logic O_IRQ_ACCEPT,
  // Data-space read answer
  output logic [7:0] O_MEM_RDATA,
  output logic O_MEM_HIT
);

  logic [7:0] gpr_ff [32];
  logic [7:0] flag_ff;
  logic [15:0] sp_ff;
  logic [7:0] temp_ff;
  logic [7:0] nxt_flag;
  logic [15:0] nxt_sp;

  // Data-space address translation; I/O instructions cover 0x00-0x3F only
  wire [7:0] data_addr = I_MEM.io ? (I_MEM.addr + `IO_TO_DATA_OFS) : I_MEM.addr;
  wire io_ok = !I_MEM.io || (I_MEM.addr <= `IO_SPACE_TOP);
  wire is_gpr = io_ok && (data_addr <= `REGFILE_TOP);
  wire is_flag = io_ok && (data_addr == `FLAG_DATA_ADDR);
  wire is_sp_lo = io_ok && (data_addr == `STKPTR_LO_ADDR);
  wire is_sp_hi = io_ok && (data_addr == `STKPTR_HI_ADDR);
  wire mem_wr = I_MEM.wr;
  wire mem_rd = I_MEM.rd;

  // Pointer base: lower register holds low byte
  wire [4:0] ptr_lo_idx = (I_PTR_SEL == 2'd0) ? `PTR_X_LO :
                          (I_PTR_SEL == 2'd1) ? `PTR_Y_LO : `PTR_Z_LO;
  wire [4:0] ptr_hi_idx = ptr_lo_idx + 5'd1;
  wire [15:0] ptr_val = {gpr_ff[ptr_hi_idx], gpr_ff[ptr_lo_idx]};
  wire [15:0] ptr_dec = ptr_val - 16'h0001;
  wire [15:0] ptr_inc = ptr_val + 16'h0001;
  wire [15:0] ptr_addr = (I_PTR_MODE == PTR_PREDEC) ? ptr_dec :
                         (I_PTR_MODE == PTR_DISP) ? (ptr_val + {10'h000, I_PTR_DISP}) : ptr_val;
  wire ptr_wb = I_PTR_EN && (I_PTR_MODE != PTR_DISP);
  wire [15:0] ptr_new = (I_PTR_MODE == PTR_PREDEC) ? ptr_dec : ptr_inc;

  // Bit load value inserted into selected bit
  wire [7:0] bit_ins_val = (gpr_ff[I_WR_SEL] & ~(8'h01 << I_BIT_SEL)) |
                       ({7'h00, flag_ff[`FLAG_T]} << I_BIT_SEL);
  wire bit_src = gpr_ff[I_RD_A_SEL][I_BIT_SEL];

  // Register file: one generate loop, each entry chooses its writer
  for (genvar g = 0; g < 32; g++) begin : gen_gpr
    wire [4:0] idx = 5'(g);
    wire wr_lo = I_WR_EN && (I_WR_SEL == idx);
    wire wr_hi = I_WR_EN && I_WR_WIDE && ((I_WR_SEL + 5'd1) == idx);
    wire wr_mem = mem_wr && is_gpr && (data_addr[4:0] == idx);
    wire wr_bitld = I_BIT_LOAD && (I_WR_SEL == idx);
    wire wr_plo = ptr_wb && (ptr_lo_idx == idx);
    wire wr_phi = ptr_wb && (ptr_hi_idx == idx);
    always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
        gpr_ff[g] <= 8'h00;
      end else if (wr_bitld) begin
        gpr_ff[g] <= bit_ins_val;
      end else if (wr_lo) begin
        gpr_ff[g] <= I_WR_DATA[7:0];
      end else if (wr_hi) begin
        gpr_ff[g] <= I_WR_DATA[15:8];
      end else if (wr_plo) begin
        gpr_ff[g] <= ptr_new[7:0];
      end else if (wr_phi) begin
        gpr_ff[g] <= ptr_new[15:8];
      end else if (wr_mem) begin
        gpr_ff[g] <= I_MEM.wdata;
      end
    end
  end

  // Flag register next value: events override software byte write
  wire [7:0] um = I_FLAG_UPD.mask;
  wire new_n = um[`FLAG_N] ? I_FLAG_UPD.n : flag_ff[`FLAG_N];
  wire new_v = um[`FLAG_V] ? I_FLAG_UPD.v : flag_ff[`FLAG_V];
  wire irq_accept = I_IRQ_PENDING && flag_ff[`FLAG_I];
  always_comb begin
    nxt_flag = (mem_wr && is_flag) ? I_MEM.wdata : flag_ff;
    if (um != 8'h00) begin
      nxt_flag[`FLAG_C] = um[`FLAG_C] ? I_FLAG_UPD.c : flag_ff[`FLAG_C];
      nxt_flag[`FLAG_Z] = um[`FLAG_Z] ? I_FLAG_UPD.z : flag_ff[`FLAG_Z];
      nxt_flag[`FLAG_N] = new_n;
      nxt_flag[`FLAG_V] = new_v;
      nxt_flag[`FLAG_S] = new_n ^ new_v;
      nxt_flag[`FLAG_H] = um[`FLAG_H] ? I_FLAG_UPD.h : flag_ff[`FLAG_H];
    end
    if (I_BIT_STORE) begin
      nxt_flag[`FLAG_T] = bit_src;
    end
    if (I_SET_IE || I_SP_OP == SP_IRQ_RET) begin
      nxt_flag[`FLAG_I] = 1'b1;
    end
    if (I_CLR_IE || I_IRQ_TAKEN) begin
      nxt_flag[`FLAG_I] = 1'b0;
    end
  end

  // Stack pointer next value; only bits 10:0 are held
  always_comb begin
    nxt_sp = sp_ff;
    case (I_SP_OP)
      SP_NONE: nxt_sp = sp_ff;
      SP_PUSH: nxt_sp = sp_ff - 16'h0001;
      SP_POP: nxt_sp = sp_ff + 16'h0001;
      SP_CALL: nxt_sp = sp_ff - 16'h0002;
      SP_RET: nxt_sp = sp_ff + 16'h0002;
      SP_IRQ_RET: nxt_sp = sp_ff + 16'h0002;
      default: nxt_sp = sp_ff;
    endcase
    if (mem_wr && is_sp_hi) begin
      nxt_sp = {I_MEM.wdata, temp_ff};
    end
    nxt_sp = nxt_sp & `SP_WMASK;
  end

  // Temporary byte: low write stores it, low read latches high byte
  wire [7:0] sp_hi = sp_ff[15:8];
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      temp_ff <= 8'h00;
    end else if (mem_wr && is_sp_lo) begin
      temp_ff <= I_MEM.wdata;
    end else if (mem_rd && is_sp_lo) begin
      temp_ff <= sp_hi;
    end
  end

  // State registers; flag register untouched by entry and return beyond enable
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      flag_ff <= `FLAG_RESET;
      sp_ff <= `SP_RESET;
    end else begin
      flag_ff <= nxt_flag;
      sp_ff <= nxt_sp;
    end
  end

  // Read data selection
  wire [7:0] mem_rdata = is_gpr ? gpr_ff[data_addr[4:0]] :
                         is_flag ? flag_ff :
                         is_sp_lo ? sp_ff[7:0] :
                         is_sp_hi ? temp_ff : 8'h00;
  wire [15:0] rd_b = I_RD_WIDE ? {gpr_ff[I_RD_B_SEL + 5'd1], gpr_ff[I_RD_B_SEL]} :
                     {8'h00, gpr_ff[I_RD_B_SEL]};

  // Registered outputs
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_RD_A <= 8'h00;
      O_RD_B <= 16'h0000;
      O_PTR_ADDR <= 16'h0000;
      O_FLAGS <= `FLAG_RESET;
      O_SP <= `SP_RESET;
      O_IRQ_ACCEPT <= 1'b0;
      O_MEM_RDATA <= 8'h00;
      O_MEM_HIT <= 1'b0;
    end else begin
      O_RD_A <= gpr_ff[I_RD_A_SEL];
      O_RD_B <= rd_b;
      O_PTR_ADDR <= ptr_addr;
      O_FLAGS <= nxt_flag;
      O_SP <= nxt_sp;
      O_IRQ_ACCEPT <= irq_accept;
      O_MEM_RDATA <= mem_rdata;
      O_MEM_HIT <= mem_rd && (is_gpr || is_flag || is_sp_lo || is_sp_hi);
    end
  end

  // Checks
  sequence irq_enter_s;
    I_IRQ_TAKEN && !I_SET_IE && I_SP_OP != SP_IRQ_RET;
  endsequence
  sign_relation_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (I_FLAG_UPD.mask != 8'h00) |=> (flag_ff[`FLAG_S] == (flag_ff[`FLAG_N] ^ flag_ff[`FLAG_V])))
    else $error("sign flag mismatch");
  irq_gate_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    !flag_ff[`FLAG_I] |=> !O_IRQ_ACCEPT)
    else $error("interrupt accepted while disabled");
  irq_clear_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    irq_enter_s |=> !flag_ff[`FLAG_I])
    else $error("enable not cleared on entry");
  irq_ret_set_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (I_SP_OP == SP_IRQ_RET && !I_CLR_IE && !I_IRQ_TAKEN) |=> flag_ff[`FLAG_I])
    else $error("enable not set on return");
  push_step_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (I_SP_OP == SP_PUSH && !mem_wr) |=> (sp_ff == ((16'($past(sp_ff)) - 16'h0001) & `SP_WMASK)))
    else $error("push step wrong");
  call_step_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (I_SP_OP == SP_CALL && !mem_wr) |=> (sp_ff == ((16'($past(sp_ff)) - 16'h0002) & `SP_WMASK)))
    else $error("call step wrong");
  // Pops and returns move the stack pointer back up
  pop_step_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (I_SP_OP == SP_POP && !mem_wr) |=> (sp_ff == ((16'($past(sp_ff)) + 16'h0001) & `SP_WMASK)))
    else $error("pop step wrong");
  ret_step_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    ((I_SP_OP == SP_RET || I_SP_OP == SP_IRQ_RET) && !mem_wr) |=>
    (sp_ff == ((16'($past(sp_ff)) + 16'h0002) & `SP_WMASK)))
    else $error("return step wrong");
  sp_upper_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    sp_ff[15:11] == 5'h00)
    else $error("stack pointer upper bits set");
  flag_keep_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (um == 8'h00 && !mem_wr && !I_BIT_STORE && !I_SET_IE && !I_CLR_IE && !I_IRQ_TAKEN
     && I_SP_OP != SP_IRQ_RET) |=> $stable(flag_ff))
    else $error("flags changed without cause");
  bit_store_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    I_BIT_STORE |=> (flag_ff[`FLAG_T] == $past(bit_src)))
    else $error("copy bit not stored");
  // Byte access answers and refusals
  flag_read_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (mem_rd && is_flag) |=> (O_MEM_RDATA == $past(flag_ff)))
    else $error("flag register read wrong");
  io_refuse_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (mem_rd && I_MEM.io && (I_MEM.addr > `IO_SPACE_TOP)) |=> !O_MEM_HIT)
    else $error("out of range I/O read answered");
  hi_read_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    (mem_rd && is_sp_lo && !mem_wr) |=> (temp_ff == $past(sp_hi)))
    else $error("high byte not latched");
  // 16-bit access pairs: low byte then high byte in consecutive cycles
  sequence pair_write_s;
    (mem_wr && is_sp_lo) ##1 (mem_wr && is_sp_hi);
  endsequence
  sequence pair_read_s;
    (mem_rd && is_sp_lo && !mem_wr) ##1 (mem_rd && is_sp_hi);
  endsequence
  pair_write_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    pair_write_s |=> (sp_ff == ({$past(I_MEM.wdata), $past(I_MEM.wdata, 2)} & `SP_WMASK)))
    else $error("high write did not load both bytes");
  pair_read_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
    pair_read_s |=> (O_MEM_RDATA == $past(sp_hi, 2)))
    else $error("high read not from latched byte");

endmodule

// file: pkg/cpu_state_regs.svh
// Offsets, field positions, reset values and stack pointer mask for the CPU state block
// Included by the package and the design; definitions only
`ifndef CPU_STATE_REGS_SVH
`define CPU_STATE_REGS_SVH
`define FLAG_DATA_ADDR 8'h5F
`define IO_TO_DATA_OFS 8'h20
`define STKPTR_LO_ADDR 8'h5D
`define STKPTR_HI_ADDR 8'h5E
`define IO_SPACE_TOP 8'h3F
`define EXT_IO_BASE 8'h60
`define REGFILE_TOP 8'h1F
`define FLAG_RESET 8'h00
`define SP_RESET 16'h04FF
`define SP_WMASK 16'h07FF
`define FLAG_I 7
`define FLAG_T 6
`define FLAG_H 5
`define FLAG_S 4
`define FLAG_V 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define PTR_X_LO 5'd26
`define PTR_Y_LO 5'd28
`define PTR_Z_LO 5'd30
`endif

// file: pkg/cpu_state_pkg.sv
// Types shared by the CPU state block and its surroundings
// Assumes the constants header is on the include path
`include "cpu_state_regs.svh"
package cpu_state_pkg;
  // Stack pointer adjustment requests
  typedef enum logic [5:0] {
    SP_NONE = 6'b00_0001,
    SP_PUSH = 6'b00_0010,
    SP_POP = 6'b00_0100,
    SP_CALL = 6'b00_1000,
    SP_RET = 6'b01_0000,
    SP_IRQ_RET = 6'b10_0000
  } sp_op_e;
  // Pointer use in indirect addressing
  typedef enum logic [2:0] {
    PTR_DISP = 3'b001,
    PTR_POSTINC = 3'b010,
    PTR_PREDEC = 3'b100
  } ptr_mode_e;
  // Flag update from the arithmetic unit: mask selects flags written
  typedef struct packed {
    logic [7:0] mask;
    logic h;
    logic v;
    logic n;
    logic z;
    logic c;
  } flag_upd_s;
  // Data-space byte access from load/store or I/O instructions
  typedef struct packed {
    logic rd;
    logic wr;
    logic io;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_acc_s;
endpackage

// file: test/irq_ctl_model.sv
// Partner model: the interrupt entry side of the instruction decoder
// Assumes the core's accept output is registered on the same clock
`timescale 1ns/1ns
module irq_ctl_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Handshake with the core
  input wire logic i_accept,
  output logic o_taken
);
  logic gap;
  // One entry per accept; the gap covers the stale accept after entry
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_taken <= 1'b0;
      gap <= 1'b0;
    end else begin
      o_taken <= i_accept & ~o_taken & ~gap;
      gap <= o_taken;
    end
  end
endmodule

// file: test/cpu_state_test.sv
// Self-checking bench for the CPU state block
// Assumes the partner model drives interrupt entry; bench drives the rest
`timescale 1ns/1ns
module cpu_state_test
  import cpu_state_pkg::*;
;
  typedef struct {sp_op_e op; logic [15:0] sp;} row_s;
  row_s rows[5] = '{'{SP_PUSH, 16'h04FE}, '{SP_POP, 16'h04FF}, '{SP_CALL, 16'h04FD},
    '{SP_RET, 16'h04FF}, '{SP_IRQ_RET, 16'h0501}};
  logic clk, rst, rd_wide, wr_en, wr_wide, bit_st, bit_ld, pend, set_ie, clr_ie, ptr_en, taken, acc, hit;
  logic [4:0] ra, rb, ws;
  logic [15:0] wd, rd_b, paddr, sp;
  logic [7:0] rd_a, flags, mrd;
  logic [2:0] bsel;
  logic [1:0] psel;
  logic [5:0] disp;
  flag_upd_s fu;
  mem_acc_s mem;
  sp_op_e op;
  ptr_mode_e pm;
  int miscompares, checks_done, cyc;
  cpu_state dut (.I_CLOCK(clk), .I_RESET(rst), .I_RD_A_SEL(ra), .I_RD_B_SEL(rb), .I_RD_WIDE(rd_wide),
    .I_WR_SEL(ws), .I_WR_EN(wr_en), .I_WR_WIDE(wr_wide), .I_WR_DATA(wd), .I_FLAG_UPD(fu),
    .I_BIT_STORE(bit_st), .I_BIT_LOAD(bit_ld), .I_BIT_SEL(bsel), .I_IRQ_PENDING(pend), .I_IRQ_TAKEN(taken),
    .I_SET_IE(set_ie), .I_CLR_IE(clr_ie), .I_SP_OP(taken ? SP_CALL : op), .I_PTR_SEL(psel),
    .I_PTR_MODE(pm), .I_PTR_EN(ptr_en), .I_PTR_DISP(disp), .I_MEM(mem), .O_RD_A(rd_a),
    .O_RD_B(rd_b), .O_PTR_ADDR(paddr), .O_FLAGS(flags), .O_SP(sp), .O_IRQ_ACCEPT(acc),
    .O_MEM_RDATA(mrd), .O_MEM_HIT(hit));
  irq_ctl_model partner (.i_clock(clk), .i_reset(rst), .i_accept(acc), .o_taken(taken));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic mem_op(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    // Request stays up until the next request or an explicit clear
    mem = '{~w, w, io, a, d};
    step();
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, rd_wide, wr_en, wr_wide, bit_st, bit_ld, pend, set_ie, clr_ie, ptr_en} = 10'h200;
    {ra, rb, ws, wd, bsel, psel, disp} = '0;
    fu = '0;
    mem = '0;
    op = SP_NONE;
    pm = PTR_DISP;
    repeat (2) step();
    rst = 1'b0;
    check("sp_rst", sp, 16'h04FF);
    check("flag_rst", {8'h00, flags}, 16'h0000);
    fu = '{8'h2F, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    step();
    check("alu_flags", {8'h00, flags}, 16'h003B);
    fu = '{8'h04, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    step();
    fu = '0;
    check("n_only", {8'h00, flags}, 16'h002F);
    // Stack pointer is already valid before any call or enable
    foreach (rows[i]) begin
      op = rows[i].op;
      step();
      check("sp_op", sp, rows[i].sp);
    end
    op = SP_NONE;
    check("iret_i", {8'h00, flags}, 16'h00AF);
    clr_ie = 1'b1;
    step();
    clr_ie = 1'b0;
    pend = 1'b1;
    check("cli", {8'h00, flags}, 16'h002F);
    repeat (3) step();
    check("masked", {15'h0, acc}, 16'h0000);
    set_ie = 1'b1;
    step();
    set_ie = 1'b0;
    check("sei", {8'h00, flags}, 16'h00AF);
    for (int k = 0; k < 6 && flags[7] !== 1'b0; k++) step();
    check("accept", {15'h0, acc}, 16'h0001);
    pend = 1'b0;
    check("entry_flags", {8'h00, flags}, 16'h002F);
    check("entry_sp", sp, 16'h04FF);
    ws = 5'd3;
    wd = 16'h0080;
    wr_en = 1'b1;
    step();
    wr_en = 1'b0;
    ra = 5'd3;
    bsel = 3'd7;
    bit_st = 1'b1;
    step();
    bit_st = 1'b0;
    check("t_store", {8'h00, flags}, 16'h006F);
    ws = 5'd4;
    bsel = 3'd2;
    bit_ld = 1'b1;
    step();
    bit_ld = 1'b0;
    ra = 5'd4;
    step();
    check("t_load", {8'h00, rd_a}, 16'h0004);
    mem_op(1'b1, 1'b0, 8'h5F, 8'hA5);
    check("flag_wr", {8'h00, flags}, 16'h00A5);
    mem_op(1'b0, 1'b1, 8'h3F, 8'h00);
    check("flag_io", {7'h0, hit, mrd}, 16'h01A5);
    mem_op(1'b1, 1'b0, 8'h5D, 8'h34);
    check("sp_temp", sp, 16'h04FF);
    mem_op(1'b1, 1'b1, 8'h3E, 8'hFA);
    check("sp_wr", sp, 16'h0234);
    mem_op(1'b0, 1'b0, 8'h5D, 8'h00);
    check("spl_rd", {8'h00, mrd}, 16'h0034);
    mem_op(1'b0, 1'b0, 8'h5E, 8'h00);
    check("sph_rd", {8'h00, mrd}, 16'h0002);
    mem_op(1'b0, 1'b1, 8'h7D, 8'h00);
    check("ext_io", {7'h0, hit, mrd}, 16'h0000);
    mem_op(1'b1, 1'b0, 8'h1A, 8'h34);
    mem_op(1'b1, 1'b0, 8'h1B, 8'h12);
    mem = '0;
    disp = 6'd5;
    ptr_en = 1'b1;
    step();
    check("disp", paddr, 16'h1239);
    pm = PTR_POSTINC;
    step();
    check("postinc", paddr, 16'h1234);
    pm = PTR_PREDEC;
    step();
    ptr_en = 1'b0;
    check("predec", paddr, 16'h1234);
    ws = 5'd30;
    wd = 16'hBEEF;
    {wr_wide, wr_en, rd_wide, rb, ra} = {3'b111, 5'd26, 5'd31};
    step();
    {wr_wide, wr_en} = 2'b00;
    check("x_back", rd_b, 16'h1234);
    rb = 5'd30;
    psel = 2'd2;
    pm = PTR_DISP;
    step();
    check("z_wide", rd_b, 16'hBEEF);
    check("z_high", {8'h00, rd_a}, 16'h00BE);
    check("z_disp", paddr, 16'hBEF4);
    // Reset again in mid-run: state returns to its reset values
    rst = 1'b1;
    repeat (2) step();
    rst = 1'b0;
    check("sp_rst2", sp, 16'h04FF);
    check("flag_rst2", {8'h00, flags}, 16'h0000);
    step();
    check("reg_rst2", {8'h00, rd_a}, 16'h0000);
    wrap_up();
  end
endmodule
